// ### verilog/pmlp_top.sv
// port merge control, deactivated-port gating and per-lane polarity
`timescale 1ns/10ps
module pmlp_top
	import pmlp_pkg::*;
#(
	parameter int NP = NUM_PORTS,
	parameter int LPP = LANES_PER_PORT,
	parameter int NPART = NUM_PARTS
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NP/2-1:0] pair_merge_en_n,
	input wire logic [NP-1:0] attn_button_in,
	input wire logic [NP-1:0] retention_latch_in,
	input wire logic [NP-1:0] presence_detect_in,
	input wire logic [NP-1:0] power_fault_in,
	input wire logic [NP-1:0] slot_power_good_in,
	input wire logic [NP-1:0][1:0] port_opmode_ctl,
	input wire logic [NP-1:0] port_ltssm_detect,
	input wire logic [NP-1:0] port_training,
	input wire logic [NP-1:0] port_link_up,
	input wire logic [NP-1:0] port_activity,
	input wire logic [NP-1:0] port_cfg_req,
	input wire logic [NP-1:0] port_reg_sel,
	input wire logic [NP-1:0][PART_W-1:0] port_part_id,
	input wire logic [NPART-1:0] part_reset,
	input wire logic [NP-1:0] port_part_event,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] rx_code,
	input wire logic [NP*LPP-1:0] rx_code_valid,
	input wire logic [NP*LPP-1:0] rx_in_ts,
	input wire logic [NP*LPP-1:0][3:0] rx_ts_idx,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] tx_code_in,
	input wire logic [NP*LPP-1:0] tx_code_valid_in,
	output logic [NP-1:0] port_active,
	output logic [NP-1:0][WIDTH_W-1:0] port_lane_width,
	output logic [NP-1:0] port_low_power,
	output logic [NP-1:0] port_link_assoc,
	output logic [NP-1:0] port_cfg_req_out,
	output logic [NP-1:0] port_reg_sel_out,
	output logic [NP-1:0] port_in_hierarchy,
	output logic [NP-1:0] port_part_reset,
	output logic [NPART-1:0] part_event,
	output logic [NP-1:0] port_is_upstream,
	output logic [NP-1:0] port_is_downstream,
	output logic [NP-1:0] full_retrain,
	output logic [NP-1:0] port_linkup_ind_n,
	output logic [NP-1:0] port_activity_ind_n,
	output logic [NP-1:0] hp_attn_n,
	output logic [NP-1:0] hp_latch_n,
	output logic [NP-1:0] hp_present_n,
	output logic [NP-1:0] hp_fault_n,
	output logic [NP-1:0] hp_pwr_good_n,
	output logic [NP*LPP-1:0][CODE_W-1:0] rx_code_out,
	output logic [NP*LPP-1:0] rx_code_out_valid,
	output logic [NP*LPP-1:0] rx_lane_inverted,
	output logic [NP*LPP-1:0][CODE_W-1:0] tx_code_out,
	output logic [NP*LPP-1:0] tx_code_valid_out
);

	localparam int NL = NP * LPP;

	logic rst_s1_ff;
	logic rst_n_ff;
	logic [NP/2-1:0] merge_s1_ff;
	logic [NP/2-1:0] merge_s2_ff;
	logic [NP/2-1:0] merge_cfg_ff;
	logic [1:0] cap_cnt_ff;
	pmlp_cap_t cap_state_ff;
	logic [4:0][NP-1:0] hp_s1_ff;
	logic [4:0][NP-1:0] hp_s2_ff;
	logic [NP-1:0] active;
	logic [NP-1:0] detect_prev_ff;
	pmlp_mode_t [NP-1:0] mode;

	// owning port of a lane; lanes of a merged odd port join the even one
	function automatic int lane_owner(input int lane, input logic [NP/2-1:0] cfg);
		int p;
		p = lane / LPP;
		if ((p % 2) == 1 && cfg[p/2])
			p = p - 1;
		return p;
	endfunction

	function automatic pmlp_mode_t decode_mode(input logic [1:0] ctl, input logic act);
		pmlp_mode_t m;
		m = PMLP_MODE_OFF;
		if (!act)
			m = PMLP_MODE_OFF;
		else if (ctl == MODE_CODE_USP)
			m = PMLP_MODE_USP;
		else if (ctl == MODE_CODE_DSP)
			m = PMLP_MODE_DSP;
		return m;
	endfunction

	// reset release through two flops
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_s1_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_n_ff <= rst_s1_ff;
		end
	end

	// merge strap pins synchronised
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			merge_s1_ff <= {(NP/2){STRAP_RESET}};
			merge_s2_ff <= {(NP/2){STRAP_RESET}};
		end
		else
		begin
			merge_s1_ff <= pair_merge_en_n;
			merge_s2_ff <= merge_s1_ff;
		end
	end

	// strap capture once per fundamental reset
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			cap_state_ff <= PMLP_CAP_WAIT;
			cap_cnt_ff <= 2'h0;
			merge_cfg_ff <= '0;
		end
		else
		begin
			case (cap_state_ff)
				PMLP_CAP_WAIT:
				begin
					merge_cfg_ff <= ~merge_s2_ff;
					cap_cnt_ff <= cap_cnt_ff + 2'h1;
					if (cap_cnt_ff == CAP_DELAY)
						cap_state_ff <= PMLP_CAP_DONE;
				end
				PMLP_CAP_DONE:
					merge_cfg_ff <= merge_cfg_ff;
				default:
					cap_state_ff <= PMLP_CAP_WAIT;
			endcase
		end
	end

	// odd port of a merged pair deactivated; opmode cannot override
	always_comb
	begin
		for (int p = 0; p < NP; p++)
		begin
			if ((p % 2) == 1)
				active[p] = !merge_cfg_ff[p/2];
			else
				active[p] = 1'b1;
			mode[p] = decode_mode(port_opmode_ctl[p], active[p]);
		end
	end

	// hot-plug pins synchronised, negated level at reset
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			hp_s1_ff <= {5{ {NP{HP_NEGATED}} }};
			hp_s2_ff <= {5{ {NP{HP_NEGATED}} }};
		end
		else
		begin
			hp_s1_ff <= {slot_power_good_in, power_fault_in, presence_detect_in,
				retention_latch_in, attn_button_in};
			hp_s2_ff <= hp_s1_ff;
		end
	end

	// hot-plug, indicator and hierarchy outputs per port
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			hp_attn_n <= {NP{HP_NEGATED}};
			hp_latch_n <= {NP{HP_NEGATED}};
			hp_present_n <= {NP{HP_NEGATED}};
			hp_fault_n <= {NP{HP_NEGATED}};
			hp_pwr_good_n <= {NP{HP_NEGATED}};
			port_linkup_ind_n <= {NP{IND_NEGATED}};
			port_activity_ind_n <= {NP{IND_NEGATED}};
			port_in_hierarchy <= '0;
			port_link_assoc <= '0;
			port_cfg_req_out <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				hp_attn_n[p] <= active[p] ? hp_s2_ff[0][p] : HP_NEGATED;
				hp_latch_n[p] <= active[p] ? hp_s2_ff[1][p] : HP_NEGATED;
				hp_present_n[p] <= active[p] ? hp_s2_ff[2][p] : HP_NEGATED;
				hp_fault_n[p] <= active[p] ? hp_s2_ff[3][p] : HP_NEGATED;
				hp_pwr_good_n[p] <= active[p] ? hp_s2_ff[4][p] : HP_NEGATED;
				port_linkup_ind_n[p] <= active[p] ? !port_link_up[p] : IND_NEGATED;
				port_activity_ind_n[p] <= active[p] ? !port_activity[p] : IND_NEGATED;
				port_in_hierarchy[p] <= active[p] && port_link_up[p];
				port_link_assoc[p] <= active[p];
				port_cfg_req_out[p] <= active[p] && port_cfg_req[p];
			end
		end
	end

	// mode, width, power and register access per port
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			port_active <= '0;
			port_low_power <= '0;
			port_is_upstream <= '0;
			port_is_downstream <= '0;
			port_lane_width <= '0;
			port_reg_sel_out <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				port_active[p] <= active[p];
				port_low_power[p] <= !active[p];
				port_is_upstream[p] <= (mode[p] == PMLP_MODE_USP);
				port_is_downstream[p] <= (mode[p] == PMLP_MODE_DSP);
				if (!active[p])
					port_lane_width[p] <= WIDTH_NONE;
				else if ((p % 2) == 0 && merge_cfg_ff[p/2])
					port_lane_width[p] <= WIDTH_X8;
				else
					port_lane_width[p] <= WIDTH_X4;
				port_reg_sel_out[p] <= port_reg_sel[p];
			end
		end
	end

	// partition membership and full retrain detection
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			port_part_reset <= '0;
			part_event <= '0;
			detect_prev_ff <= '0;
			full_retrain <= '0;
		end
		else
		begin
			for (int p = 0; p < NP; p++)
			begin
				port_part_reset[p] <= active[p] && part_reset[port_part_id[p]];
				detect_prev_ff[p] <= port_ltssm_detect[p];
				full_retrain[p] <= active[p] && port_ltssm_detect[p]
					&& !detect_prev_ff[p];
			end
			for (int q = 0; q < NPART; q++)
			begin
				part_event[q] <= 1'b0;
				for (int p = 0; p < NP; p++)
				begin
					if (active[p] && port_part_event[p]
						&& port_part_id[p] == PART_W'(q))
						part_event[q] <= 1'b1;
				end
			end
		end
	end

	// transmit path passes code groups unchanged on every lane; lanes of a merged odd port follow its always-active even port
	always_ff @(posedge clk or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			tx_code_out <= '0;
			tx_code_valid_out <= '0;
		end
		else
		begin
			for (int l = 0; l < NL; l++)
			begin
				if (active[lane_owner(l, merge_cfg_ff)])
				begin
					tx_code_out[l] <= tx_code_in[l];
					tx_code_valid_out[l] <= tx_code_valid_in[l];
				end
				else
				begin
					tx_code_out[l] <= '0;
					tx_code_valid_out[l] <= 1'b0;
				end
			end
		end
	end

	// one polarity unit per lane, lane to port wiring follows the merge configuration
	genvar g;
	generate
		for (g = 0; g < NL; g++)
		begin : g_lane
			pmlp_lane_if lif ();
			int owner;
			assign owner = lane_owner(g, merge_cfg_ff);
			assign lif.code_in = rx_code[g];
			assign lif.code_valid = rx_code_valid[g];
			assign lif.in_ts = rx_in_ts[g];
			assign lif.ts_idx = rx_ts_idx[g];
			assign lif.training = port_training[owner];
			assign lif.in_detect = port_ltssm_detect[owner];
			assign lif.enable = active[owner] && (cap_state_ff == PMLP_CAP_DONE);
			assign rx_code_out[g] = lif.code_out;
			assign rx_code_out_valid[g] = lif.code_out_valid;
			assign rx_lane_inverted[g] = lif.inverted;

			pmlp_lane_pol u_pol (
				.clk(clk),
				.rst_n(rst_n_ff),
				.lif(lif.lane)
			);
		end
	endgenerate

endmodule // pmlp_top

// ### inc/pmlp_pkg.sv
// constants and types for port merging and lane polarity logic
package pmlp_pkg;

	localparam int NUM_PORTS = 16;
	localparam int LANES_PER_PORT = 4;
	localparam int MERGED_LANES = 8;
	localparam int NUM_PAIRS = NUM_PORTS / 2;
	localparam int NUM_LANES = NUM_PORTS * LANES_PER_PORT;
	localparam int NUM_PARTS = 8;
	localparam int PART_W = 3;
	localparam int CODE_W = 10;
	localparam int WIDTH_W = 4;

	// training set symbol window checked for inversion
	localparam logic [3:0] TS_SYM_FIRST = 4'h6;
	localparam logic [3:0] TS_SYM_LAST = 4'hf;
	localparam logic [3:0] TS_INV_COUNT = 4'ha;

	// ts1 and ts2 identifier code groups, both disparities identical
	localparam logic [CODE_W-1:0] TS1_ID_CODE = 10'h155;
	localparam logic [CODE_W-1:0] TS2_ID_CODE = 10'h295;
	localparam logic [CODE_W-1:0] TS1_ID_INV = ~TS1_ID_CODE;
	localparam logic [CODE_W-1:0] TS2_ID_INV = ~TS2_ID_CODE;

	// strap capture delay after reset release, covers pin synchroniser
	localparam logic [1:0] CAP_DELAY = 2'h3;

	localparam logic IND_NEGATED = 1'b1;
	localparam logic HP_NEGATED = 1'b1;
	localparam logic STRAP_RESET = 1'b1;

	localparam logic [1:0] MODE_CODE_USP = 2'h0;
	localparam logic [1:0] MODE_CODE_DSP = 2'h1;

	localparam logic [WIDTH_W-1:0] WIDTH_NONE = 4'h0;
	localparam logic [WIDTH_W-1:0] WIDTH_X4 = 4'h4;
	localparam logic [WIDTH_W-1:0] WIDTH_X8 = 4'h8;

	typedef enum logic [1:0] {
		PMLP_MODE_OFF,
		PMLP_MODE_USP,
		PMLP_MODE_DSP
	} pmlp_mode_t;

	typedef enum logic {
		PMLP_CAP_WAIT,
		PMLP_CAP_DONE
	} pmlp_cap_t;

endpackage

// ### inc/pmlp_lane_if.sv
// per-lane receive and polarity signals between port logic and lane logic
`timescale 1ns/10ps
interface pmlp_lane_if;
	import pmlp_pkg::*;
	logic [CODE_W-1:0] code_in;
	logic code_valid;
	logic in_ts;
	logic [3:0] ts_idx;
	logic training;
	logic in_detect;
	logic enable;
	logic [CODE_W-1:0] code_out;
	logic code_out_valid;
	logic inverted;

	modport port_side (
		output code_in, code_valid, in_ts, ts_idx, training, in_detect, enable,
		input code_out, code_out_valid, inverted
	);

	modport lane (
		input code_in, code_valid, in_ts, ts_idx, training, in_detect, enable,
		output code_out, code_out_valid, inverted
	);
endinterface

// ### verilog/pmlp_lane_pol.sv
// receive polarity detection and correction for one lane
`timescale 1ns/10ps
module pmlp_lane_pol
	import pmlp_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	pmlp_lane_if.lane lif
);

	logic [3:0] inv_cnt_ff;
	logic inverted_ff;
	logic [CODE_W-1:0] code_out_ff;
	logic valid_out_ff;
	logic in_window;
	logic inv_match;

	assign in_window = lif.code_valid && lif.in_ts && lif.training
		&& (lif.ts_idx >= TS_SYM_FIRST) && (lif.ts_idx <= TS_SYM_LAST);
	assign inv_match = (lif.code_in == TS1_ID_INV) || (lif.code_in == TS2_ID_INV);

	// run of inverted identifiers within one training set
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			inv_cnt_ff <= 4'h0;
		else if (!lif.enable || lif.in_detect)
			inv_cnt_ff <= 4'h0;
		else if (in_window)
		begin
			if (lif.ts_idx == TS_SYM_FIRST)
				inv_cnt_ff <= inv_match ? 4'h1 : 4'h0;
			else if (inv_match && inv_cnt_ff != TS_INV_COUNT)
				inv_cnt_ff <= inv_cnt_ff + 4'h1;
			else
				inv_cnt_ff <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			inverted_ff <= 1'b0;
		else if (!lif.enable || lif.in_detect)
			inverted_ff <= 1'b0;
		else if (in_window && inv_match && lif.ts_idx == TS_SYM_LAST
			&& inv_cnt_ff == TS_INV_COUNT - 4'h1)
			inverted_ff <= 1'b1;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			code_out_ff <= '0;
			valid_out_ff <= 1'b0;
		end
		else
		begin
			code_out_ff <= !lif.enable ? '0 : (inverted_ff ? ~lif.code_in : lif.code_in);
			valid_out_ff <= lif.enable && lif.code_valid;
		end
	end

	assign lif.code_out = code_out_ff;
	assign lif.code_out_valid = valid_out_ff;
	assign lif.inverted = inverted_ff;

endmodule // pmlp_lane_pol

// ### bench/pmlp_properties.sv
// assertions on port gating, retrain and lane polarity
`timescale 1ns/10ps
module pmlp_props
	import pmlp_pkg::*;
#(
	parameter int NP = NUM_PORTS,
	parameter int LPP = LANES_PER_PORT,
	parameter int NPART = NUM_PARTS
)
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NP-1:0] port_ltssm_detect,
	input wire logic [NP-1:0] port_link_up,
	input wire logic [NP-1:0] port_cfg_req,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] tx_code_in,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] rx_code,
	input wire logic [NP-1:0] port_active,
	input wire logic [NP-1:0][WIDTH_W-1:0] port_lane_width,
	input wire logic [NP-1:0] port_low_power,
	input wire logic [NP-1:0] port_link_assoc,
	input wire logic [NP-1:0] port_cfg_req_out,
	input wire logic [NP-1:0] port_in_hierarchy,
	input wire logic [NP-1:0] port_is_upstream,
	input wire logic [NP-1:0] port_is_downstream,
	input wire logic [NP-1:0] full_retrain,
	input wire logic [NP-1:0] port_linkup_ind_n,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] rx_code_out,
	input wire logic [NP*LPP-1:0] rx_code_out_valid,
	input wire logic [NP*LPP-1:0] rx_lane_inverted,
	input wire logic [NP*LPP-1:0][CODE_W-1:0] tx_code_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// waits out internal reset and strap capture
	logic [3:0] up_ff;
	logic live;
	always_ff @(posedge clk or negedge reset_n)
		if (!reset_n)
			up_ff <= 4'h0;
		else if (up_ff != 4'hf)
			up_ff <= up_ff + 4'h1;
	assign live = (up_ff == 4'hf);

	a_low_power_gate: assert property (live |-> port_low_power == ~port_active)
		else $error("low power differs from inactive");
	a_link_assoc: assert property (live |-> port_link_assoc == port_active)
		else $error("link association wrong");
	a_cfg_req_gate: assert property (live |->
		port_cfg_req_out == ($past(port_cfg_req) & port_active))
		else $error("config request gating wrong");
	a_hier_gate: assert property (live |->
		port_in_hierarchy == ($past(port_link_up) & port_active))
		else $error("hierarchy membership wrong");
	a_linkup_ind: assert property (live |->
		port_linkup_ind_n == ~($past(port_link_up) & port_active))
		else $error("link-up indicator wrong");
	a_mode_off: assert property (live |->
		((port_is_upstream | port_is_downstream) & ~port_active) == '0)
		else $error("inactive port has a mode");
	a_pair_width: assert property (live && port_lane_width[0] == WIDTH_X8
		|-> !port_active[1])
		else $error("odd port of merged pair active");
	a_tx_plain: assert property (live |-> tx_code_out == $past(tx_code_in))
		else $error("transmit data altered");
	a_retrain_pulse: assert property (live |-> full_retrain == ($past(port_ltssm_detect)
		& ~$past(port_ltssm_detect, 2) & port_active))
		else $error("full retrain pulse wrong");
	a_inv_clear: assert property ($rose(port_ltssm_detect[0])
		|-> ##[1:2] !rx_lane_inverted[0])
		else $error("inversion kept over detect");
	a_rx_corrected: assert property (rx_code_out_valid[0] && rx_lane_inverted[0]
		&& $past(rx_lane_inverted[0], 2) |-> rx_code_out[0] == ~$past(rx_code[0]))
		else $error("received data not inverted");

	c_inverted: cover property ($rose(rx_lane_inverted[0]));
	c_retrain: cover property (full_retrain[0]);
	c_merged: cover property (port_lane_width[0] == WIDTH_X8);
endmodule // pmlp_props

// ### bench/pmlp_link_partner.sv
// far-end model: idle, training sets or data on one lane
`timescale 1ns/10ps
module pmlp_link_partner
	import pmlp_pkg::*;
(
	input wire logic clk,
	input wire logic [1:0] mode,
	input wire logic inv,
	output logic [CODE_W-1:0] code,
	output logic valid,
	output logic in_ts,
	output logic [3:0] idx
);
	logic [3:0] cnt = 4'h0;
	initial
		code = 10'h0f0;

	always @(posedge clk)
	begin
		valid <= (mode != 2'h0);
		in_ts <= (mode == 2'h1);
		cnt <= (mode == 2'h1) ? cnt + 4'h1 : 4'h0;
		idx <= cnt;
		if (mode == 2'h1)
			code <= (cnt >= TS_SYM_FIRST) ? (inv ? TS1_ID_INV : TS1_ID_CODE) : 10'h17c;
		else if (mode == 2'h2)
			code <= code + 10'h02d;
		else
			code <= ~code; // released line toggles
	end
endmodule // pmlp_link_partner

// ### bench/pmlp_top_tb.sv
// testbench for port merge and lane polarity logic
`timescale 1ns/10ps
module pmlp_top_tb;
	import pmlp_pkg::*;
	localparam int NP = NUM_PORTS;
	localparam int NL = NUM_LANES;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [NP-1:0] attn_button_in, retention_latch_in, presence_detect_in, power_fault_in;
	logic [NP-1:0] slot_power_good_in, port_ltssm_detect, port_training, port_link_up;
	logic [NP-1:0] port_activity, port_cfg_req, port_reg_sel, port_part_event;
	logic [NP-1:0] port_active, port_low_power, port_link_assoc, port_cfg_req_out;
	logic [NP-1:0] port_reg_sel_out, port_in_hierarchy, port_part_reset, port_is_upstream;
	logic [NP-1:0] port_is_downstream, full_retrain, port_linkup_ind_n, port_activity_ind_n;
	logic [NP-1:0] hp_attn_n, hp_latch_n, hp_present_n, hp_fault_n, hp_pwr_good_n;
	logic [NP-1:0][1:0] port_opmode_ctl;
	logic [NP-1:0][PART_W-1:0] port_part_id;
	logic [NP-1:0][WIDTH_W-1:0] port_lane_width;
	logic [7:0] pair_merge_en_n, part_reset, part_event;
	logic [NL-1:0][CODE_W-1:0] rx_code, tx_code_in, rx_code_out, tx_code_out;
	logic [NL-1:0] rx_code_valid, rx_in_ts, tx_code_valid_in;
	logic [NL-1:0] rx_code_out_valid, rx_lane_inverted, tx_code_valid_out;
	logic [NL-1:0][3:0] rx_ts_idx;
	logic [1:0] pmode = 2'h0;
	logic pinv = 1'b0;
	logic [CODE_W-1:0] pc;
	logic pv, pt;
	logic [3:0] pi;
	int n_errors = 0;
	int checks = 0;
	int cycles = 0;

	always #50 clk = ~clk;

	pmlp_link_partner u_far (.clk, .mode(pmode), .inv(pinv), .code(pc), .valid(pv),
		.in_ts(pt), .idx(pi));
	// lane 1 carries the complement of lane 0
	assign rx_code = {{(NL-2){10'h000}}, ~pc, pc};
	assign rx_code_valid = {{(NL-2){1'b0}}, pv, pv};
	assign rx_in_ts = {{(NL-2){1'b0}}, pt, pt};
	assign rx_ts_idx = {{(NL-2){4'h0}}, pi, pi};

	pmlp_top dut (.clk, .reset_n, .pair_merge_en_n, .attn_button_in, .retention_latch_in,
		.presence_detect_in, .power_fault_in, .slot_power_good_in, .port_opmode_ctl,
		.port_ltssm_detect, .port_training, .port_link_up, .port_activity, .port_cfg_req,
		.port_reg_sel, .port_part_id, .part_reset, .port_part_event, .rx_code,
		.rx_code_valid, .rx_in_ts, .rx_ts_idx, .tx_code_in, .tx_code_valid_in, .port_active,
		.port_lane_width, .port_low_power, .port_link_assoc, .port_cfg_req_out,
		.port_reg_sel_out, .port_in_hierarchy, .port_part_reset, .part_event,
		.port_is_upstream, .port_is_downstream, .full_retrain, .port_linkup_ind_n,
		.port_activity_ind_n, .hp_attn_n, .hp_latch_n, .hp_present_n, .hp_fault_n,
		.hp_pwr_good_n, .rx_code_out, .rx_code_out_valid, .rx_lane_inverted, .tx_code_out,
		.tx_code_valid_out);

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task give_verdict;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task t_merge;
		@(posedge clk);
		port_link_up <= '1;
		port_cfg_req <= '1;
		port_reg_sel <= '1;
		port_activity <= '1;
		part_reset <= 8'h01;
		port_part_event <= 16'h0006;
		port_part_id[2] <= 3'h2;
		port_opmode_ctl[1] <= MODE_CODE_DSP;
		port_opmode_ctl[2] <= MODE_CODE_DSP;
		repeat (4) @(posedge clk);
		#1;
		chk("active", 3'h5, port_active[2:0]);
		chk("width0", WIDTH_X8, port_lane_width[0]);
		chk("width1", WIDTH_NONE, port_lane_width[1]);
		chk("width2", WIDTH_X4, port_lane_width[2]);
		chk("low power", 3'h2, port_low_power[2:0]);
		chk("link assoc", 3'h5, port_link_assoc[2:0]);
		chk("cfg req", 3'h5, port_cfg_req_out[2:0]);
		chk("hierarchy", 3'h5, port_in_hierarchy[2:0]);
		chk("part reset", 3'h1, port_part_reset[2:0]);
		chk("part event", 8'h04, part_event);
		chk("reg sel", 3'h7, port_reg_sel_out[2:0]);
		chk("upstream", 3'h1, port_is_upstream[2:0]);
		chk("downstream", 3'h4, port_is_downstream[2:0]);
		chk("linkup ind", 3'h2, port_linkup_ind_n[2:0]);
		chk("activity ind", 3'h2, port_activity_ind_n[2:0]);
		chk("hp all", 3'h2, hp_attn_n[2:0] & hp_latch_n[2:0] & hp_present_n[2:0]
			& hp_fault_n[2:0] & hp_pwr_good_n[2:0]);
		chk("hp any", 3'h2, hp_attn_n[2:0] | hp_latch_n[2:0] | hp_present_n[2:0]
			| hp_fault_n[2:0] | hp_pwr_good_n[2:0]);
		$display("merge test done");
	endtask

	task t_strap;
		@(posedge clk);
		pair_merge_en_n <= 8'hfd;
		repeat (4) @(posedge clk);
		#1;
		chk("strap active", 4'hd, port_active[3:0]);
		chk("strap width", WIDTH_X4, port_lane_width[3]);
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		#1;
		chk("strap resampled", 4'h7, port_active[3:0]);
		chk("strap merged width", WIDTH_X8, port_lane_width[2]);
		$display("strap test done");
	endtask

	task automatic train(input logic inv);
		@(posedge clk);
		pinv <= inv;
		pmode <= 2'h1;
		repeat (16) @(posedge clk);
		pmode <= 2'h2;
		repeat (3) @(posedge clk);
		#1;
	endtask

	task automatic t_polarity;
		logic [CODE_W-1:0] nc;
		@(posedge clk);
		port_training[0] <= 1'b1;
		tx_code_in[0] <= TS1_ID_CODE;
		tx_code_valid_in[0] <= 1'b1;
		train(1'b1);
		chk("inverted", 2'h1, rx_lane_inverted[1:0]);
		chk("tx", TS1_ID_CODE, tx_code_out[0]);
		chk("tx valid", 1'b1, tx_code_valid_out[0]);
		chk("rx valid", 2'h3, rx_code_out_valid[1:0]);
		@(posedge clk);
		nc = ~rx_code[0];
		#1;
		chk("rx lane0", nc, rx_code_out[0]);
		chk("rx lane1", nc, rx_code_out[1]);
		@(posedge clk);
		port_ltssm_detect[0] <= 1'b1;
		@(posedge clk);
		port_ltssm_detect[0] <= 1'b0;
		#1;
		chk("retrain", 16'h0001, full_retrain);
		@(posedge clk);
		#1;
		chk("retrain end", 16'h0000, full_retrain);
		chk("cleared", 2'h0, rx_lane_inverted[1:0]);
		train(1'b0);
		chk("retrained", 2'h2, rx_lane_inverted[1:0]);
		$display("polarity test done");
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			n_errors++;
			give_verdict;
		end
	end

	initial
	begin
		{attn_button_in, retention_latch_in, presence_detect_in, power_fault_in} = '0;
		{slot_power_good_in, port_ltssm_detect, port_training, port_link_up} = '0;
		{port_activity, port_cfg_req, port_reg_sel, port_part_event} = '0;
		{port_opmode_ctl, port_part_id, part_reset, tx_code_in, tx_code_valid_in} = '0;
		pair_merge_en_n = 8'hfe;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (12) @(posedge clk);
		t_merge;
		t_strap;
		t_polarity;
		give_verdict;
	end
endmodule // pmlp_top_tb

bind pmlp_top pmlp_props #(.NP(NP), .LPP(LPP), .NPART(NPART)) u_props (.clk, .reset_n,
	.port_ltssm_detect, .port_link_up, .port_cfg_req, .tx_code_in, .rx_code, .port_active,
	.port_lane_width, .port_low_power, .port_link_assoc, .port_cfg_req_out,
	.port_in_hierarchy, .port_is_upstream, .port_is_downstream, .full_retrain, .port_linkup_ind_n,
	.rx_code_out, .rx_code_out_valid, .rx_lane_inverted, .tx_code_out);
